// ### logic/hctm_pkg.sv
// Constants, types and helpers shared by the host-control message handler
package hctm_pkg;

   // Resource identifiers for the two card operating modes
   localparam logic [31:0] RES_ID_SINGLE = 32'h0020_0043;
   localparam logic [31:0] RES_ID_MULTI = 32'h0020_0081;

   // Message tags; even tags are requests, odd tags are confirmations
   localparam logic [23:0] TAG_TX_REQ = 24'h9F_8404;
   localparam logic [23:0] TAG_TX_CNF = 24'h9F_8405;
   localparam logic [23:0] TAG_RX_REQ = 24'h9F_8406;
   localparam logic [23:0] TAG_RX_CNF = 24'h9F_8407;
   localparam logic [23:0] TAG_IB_REQ = 24'h9F_8408;
   localparam logic [23:0] TAG_IB_CNF = 24'h9F_8409;

   // Confirmation status codes
   localparam logic [7:0] ST_GRANTED = 8'h00;
   localparam logic [7:0] ST_ABSENT = 8'h01;
   localparam logic [7:0] ST_BUSY = 8'h02;
   localparam logic [7:0] ST_INVALID = 8'h03;
   localparam logic [7:0] ST_OTHER = 8'h04;

   // Length field values
   localparam logic [7:0] LEN_TX_REQ = 8'h04;
   localparam logic [7:0] LEN_RX_REQ = 8'h03;
   localparam logic [7:0] LEN_CNF = 8'h01;
   localparam logic [7:0] LEN_IB_MAX = 8'h04;
   localparam logic [7:0] LEN_LONG_ONE = 8'h81;
   localparam int BODY_BYTES = 4;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_TX_LIMIT = 8'h04;
   localparam logic [7:0] REG_TX_POWER = 8'h08;
   localparam logic [7:0] REG_RX_LIMIT = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_TX_CFG = 8'h14;
   localparam logic [7:0] REG_RX_CFG = 8'h18;
   localparam logic [7:0] REG_DROPS = 8'h1C;

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [31:0] TX_LIMIT_RST = 32'hFFFF_0000;
   localparam logic [7:0] TX_POWER_RST = 8'hFF;
   localparam logic [10:0] RX_LIMIT_RST = 11'h7FF;

   // Receive frequency arithmetic in 10 kHz units
   localparam logic [15:0] RX_FREQ_BASE = 16'h1388;
   localparam logic [15:0] RX_FREQ_STEP = 16'h0005;

   // Bit rates in kbps
   localparam logic [11:0] KBPS_256 = 12'h100;
   localparam logic [11:0] KBPS_2048 = 12'h800;
   localparam logic [11:0] KBPS_1544 = 12'h608;
   localparam logic [11:0] KBPS_3088 = 12'hC10;

   // Receiver confirmation deadline
   localparam int CLK_HZ = 50_000_000;
   localparam int RX_CNF_LIMIT_MS = 500;
   localparam int RX_TIMEOUT_CYC = RX_CNF_LIMIT_MS * (CLK_HZ / 1000);

   // Software control bits
   typedef struct packed {
      logic standby_allow;
      logic homing_grant;
      logic multi_stream;
      logic rx_busy;
      logic rx_present;
      logic tx_busy;
      logic return_path;
      logic tx_present;
   } hctm_ctrl_t;

   // Transmitter setting
   typedef struct packed {
      logic [15:0] transmit_freq_khz;
      logic [7:0] transmit_power_code;
      logic [1:0] transmit_rate_code;
   } hctm_tx_cfg_t;

   // Receiver setting
   typedef struct packed {
      logic [10:0] receive_freq_code;
      logic [1:0] receive_rate_code;
      logic spectrum_invert_bit;
   } hctm_rx_cfg_t;

   // Transmit rate decode
   function automatic logic [11:0] tx_kbps(input logic [1:0] code);
      case (code)
         2'b00: tx_kbps = KBPS_256;
         2'b01: tx_kbps = KBPS_2048;
         2'b10: tx_kbps = KBPS_1544;
         default: tx_kbps = KBPS_3088;
      endcase
   endfunction : tx_kbps

   // Receive rate decode
   function automatic logic [11:0] rx_kbps(input logic [1:0] code);
      case (code)
         2'b00: rx_kbps = KBPS_2048;
         2'b01: rx_kbps = KBPS_2048;
         2'b10: rx_kbps = KBPS_1544;
         default: rx_kbps = KBPS_3088;
      endcase
   endfunction : rx_kbps

endpackage : hctm_pkg

// ### logic/hctm_cnf_tx.sv
// Confirmation message serializer: tag, length, status byte
`timescale 1ns/1ps
module hctm_cnf_tx (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic start,
   input wire logic [23:0] tag,
   input wire logic [7:0] status,
   output logic busy,
   output logic out_valid,
   output logic [7:0] out_data,
   output logic out_last,
   input wire logic out_ready
);

   logic [2:0] idx;
   logic active;
   logic [23:0] tag_q;
   logic [7:0] status_q;

   // Byte picker for a position in the message
   function automatic logic [7:0] pick(input logic [2:0] i,
                                       input logic [23:0] t,
                                       input logic [7:0] s);
      case (i)
         3'h0: pick = t[23:16];
         3'h1: pick = t[15:8];
         3'h2: pick = t[7:0];
         3'h3: pick = hctm_pkg::LEN_CNF;
         default: pick = s;
      endcase
   endfunction : pick

   // Sequencing of the five bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active <= 1'b0;
         idx <= 3'h0;
         tag_q <= 24'h00_0000;
         status_q <= 8'h00;
         out_data <= 8'h00;
      end else if (ce) begin
         if (start && !active) begin
            active <= 1'b1;
            idx <= 3'h0;
            tag_q <= tag;
            status_q <= status;
            out_data <= pick(3'h0, tag, status);
         end else if (active && out_ready) begin
            if (idx == 3'h4) begin
               active <= 1'b0;
            end else begin
               idx <= idx + 3'h1;
               out_data <= pick(idx + 3'h1, tag_q, status_q);
            end
         end
      end
   end

   assign busy = active;
   assign out_valid = active;
   assign out_last = active && (idx == 3'h4);

endmodule : hctm_cnf_tx

// ### logic/hctm_top.sv
// Host-control message handler: parses card requests, tunes, confirms
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
// Contract
// - Only one host-control session may be open at a time.
// - Session identifier differs by card stream mode.
// - Six message tags 0x9F8404..09; even requests, odd confirmations.
// - Transmit request body: 16-bit kHz frequency, power byte, rate byte.
// - Transmit power counts in 0.5 dBmV steps, code zero is 0 dBmV.
// - Transmit rate top bits: 256, 2048, 1544, 3088 kbps; rest reserved.
// - Host confirms each transmit request: tag, length, status.
// - Transmit status: granted, absent, busy, invalid, other; rest reserved.
// - Receive-only host answers every transmit request with 0x01.
// - Out-of-range transmit parameters are answered with status 0x03.
// - Receive frequency is code times 0.05 MHz plus 50 MHz; 11 bits.
// - Receive rate top bits: 2048, 2048, 1544, 3088 kbps.
// - Bit 0 of receive rate byte selects inverted spectrum.
// - Receive confirmation only after lock or 500 ms, whichever first.
// - Receive status: granted, absent, busy, invalid, other; rest reserved.
// - Refuse in-band tuning unless homing granted or standby allows.
module hctm_top #(
   parameter int RX_TIMEOUT = hctm_pkg::RX_TIMEOUT_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sess_open_req,
   input wire logic [31:0] sess_res_id,
   input wire logic sess_close,
   output logic sess_open_ack,
   output logic sess_open_nak,
   output logic sess_active,
   input wire logic req_valid,
   input wire logic [7:0] req_data,
   output logic req_ready,
   output logic cnf_valid,
   output logic [7:0] cnf_data,
   output logic cnf_last,
   input wire logic cnf_ready,
   output hctm_pkg::hctm_tx_cfg_t tx_cfg,
   output logic [11:0] tx_rate_kbps,
   output logic tx_apply,
   output hctm_pkg::hctm_rx_cfg_t rx_cfg,
   output logic [15:0] rx_freq_10khz,
   output logic [11:0] rx_rate_kbps,
   output logic rx_apply,
   input wire logic rx_locked,
   output logic ib_accept
);

   typedef enum logic [2:0] {
      S_TAG = 3'b000,
      S_LEN = 3'b001,
      S_BODY = 3'b010,
      S_EVAL = 3'b011,
      S_RXWAIT = 3'b100,
      S_SEND = 3'b101
   } hctm_state_t;

   hctm_state_t state;
   hctm_pkg::hctm_ctrl_t ctrl;
   logic [31:0] tx_limit;
   logic [7:0] tx_power_max;
   logic [10:0] rx_limit;
   logic [23:0] tag_buf;
   logic [7:0] len;
   logic [7:0] cnt;
   logic long_len;
   logic [7:0] body [hctm_pkg::BODY_BYTES];
   logic [31:0] timer;
   logic [15:0] drops;
   logic [7:0] last_tx_status;
   logic [7:0] last_rx_status;
   logic cnf_start;
   logic [23:0] cnf_tag;
   logic [7:0] cnf_status;
   logic cnf_busy;
   logic take;
   logic wr_en;
   logic mapped;
   logic [7:0] eval_status;
   logic [15:0] req_freq;
   logic tx_range_bad;
   logic rx_range_bad;

   // Session admission with one session at most
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sess_active <= 1'b0;
         sess_open_ack <= 1'b0;
         sess_open_nak <= 1'b0;
      end else if (ce) begin
         sess_open_ack <= 1'b0;
         sess_open_nak <= 1'b0;
         if (sess_close) begin
            sess_active <= 1'b0;
         end else if (sess_open_req) begin
            if (!sess_active && sess_res_id == (ctrl.multi_stream ?
                hctm_pkg::RES_ID_MULTI : hctm_pkg::RES_ID_SINGLE)) begin
               sess_active <= 1'b1;
               sess_open_ack <= 1'b1;
            end else begin
               sess_open_nak <= 1'b1;
            end
         end
      end
   end

   // Bytes are taken only while collecting a message
   assign req_ready = ce && (state == S_TAG || state == S_LEN ||
                             state == S_BODY);
   assign take = req_ready && req_valid;
   assign req_freq = {body[0], body[1]};

   // Range checks against software limits
   assign tx_range_bad = req_freq < tx_limit[15:0] ||
                         req_freq > tx_limit[31:16] ||
                         body[2] > tx_power_max;
   assign rx_range_bad = body[0][7:3] != 5'h00 ||
                         {body[0][2:0], body[1]} > rx_limit;

   // Status decision for the request held in the body buffer
   always_comb begin
      eval_status = hctm_pkg::ST_OTHER;
      case (tag_buf)
         hctm_pkg::TAG_TX_REQ: begin
            if (!ctrl.tx_present || !ctrl.return_path) begin
               eval_status = hctm_pkg::ST_ABSENT;
            end else if (len != hctm_pkg::LEN_TX_REQ || tx_range_bad) begin
               eval_status = hctm_pkg::ST_INVALID;
            end else if (ctrl.tx_busy) begin
               eval_status = hctm_pkg::ST_BUSY;
            end else begin
               eval_status = hctm_pkg::ST_GRANTED;
            end
         end
         hctm_pkg::TAG_RX_REQ: begin
            if (!ctrl.rx_present) begin
               eval_status = hctm_pkg::ST_ABSENT;
            end else if (len != hctm_pkg::LEN_RX_REQ || rx_range_bad) begin
               eval_status = hctm_pkg::ST_INVALID;
            end else if (ctrl.rx_busy) begin
               eval_status = hctm_pkg::ST_BUSY;
            end else begin
               eval_status = hctm_pkg::ST_GRANTED;
            end
         end
         hctm_pkg::TAG_IB_REQ: begin
            if (len == 8'h00 || len > hctm_pkg::LEN_IB_MAX) begin
               eval_status = hctm_pkg::ST_INVALID;
            end else if (ctrl.homing_grant || ctrl.standby_allow) begin
               eval_status = hctm_pkg::ST_GRANTED;
            end else begin
               eval_status = hctm_pkg::ST_OTHER;
            end
         end
         default: eval_status = hctm_pkg::ST_OTHER;
      endcase
   end

   // Message parser and confirmation sequencing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_TAG;
         tag_buf <= 24'h00_0000;
         len <= 8'h00;
         cnt <= 8'h00;
         long_len <= 1'b0;
         timer <= 32'h0000_0000;
         cnf_start <= 1'b0;
         cnf_tag <= 24'h00_0000;
         cnf_status <= 8'h00;
         drops <= 16'h0000;
      end else if (ce) begin
         cnf_start <= 1'b0;
         if (!sess_active) begin
            state <= S_TAG;
            cnt <= 8'h00;
            long_len <= 1'b0;
         end else begin
            case (state)
               S_TAG: begin
                  if (take) begin
                     tag_buf <= {tag_buf[15:0], req_data};
                     if (cnt == 8'h02) begin
                        cnt <= 8'h00;
                        state <= S_LEN;
                     end else begin
                        cnt <= cnt + 8'h01;
                     end
                  end
               end
               S_LEN: begin
                  if (take) begin
                     if (!long_len && req_data == hctm_pkg::LEN_LONG_ONE) begin
                        long_len <= 1'b1;
                     end else if (!long_len && req_data[7]) begin
                        drops <= drops + 16'h0001;
                        state <= S_TAG;
                     end else begin
                        long_len <= 1'b0;
                        len <= req_data;
                        state <= (req_data == 8'h00) ? S_EVAL : S_BODY;
                     end
                  end
               end
               S_BODY: begin
                  if (take) begin
                     cnt <= cnt + 8'h01;
                     if (cnt == len - 8'h01) begin
                        cnt <= 8'h00;
                        state <= S_EVAL;
                     end
                  end
               end
               S_EVAL: begin
                  cnf_tag <= tag_buf + 24'h00_0001;
                  cnf_status <= eval_status;
                  if (tag_buf == hctm_pkg::TAG_RX_REQ &&
                      eval_status == hctm_pkg::ST_GRANTED) begin
                     timer <= 32'h0000_0000;
                     state <= S_RXWAIT;
                  end else if (tag_buf == hctm_pkg::TAG_TX_REQ ||
                               tag_buf == hctm_pkg::TAG_RX_REQ ||
                               tag_buf == hctm_pkg::TAG_IB_REQ) begin
                     cnf_start <= 1'b1;
                     state <= S_SEND;
                  end else begin
                     drops <= drops + 16'h0001;
                     state <= S_TAG;
                  end
               end
               S_RXWAIT: begin
                  timer <= timer + 32'h0000_0001;
                  if (rx_locked) begin
                     cnf_status <= hctm_pkg::ST_GRANTED;
                     cnf_start <= 1'b1;
                     state <= S_SEND;
                  end else if (timer == 32'(RX_TIMEOUT - 1)) begin
                     cnf_status <= hctm_pkg::ST_OTHER;
                     cnf_start <= 1'b1;
                     state <= S_SEND;
                  end
               end
               S_SEND: begin
                  if (!cnf_start && !cnf_busy) begin
                     state <= S_TAG;
                  end
               end
               default: state <= S_TAG;
            endcase
         end
      end
   end

   // Body capture, first bytes only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < hctm_pkg::BODY_BYTES; i++) begin
            body[i] <= 8'h00;
         end
      end else if (ce) begin
         if (take && state == S_BODY && cnt < 8'(hctm_pkg::BODY_BYTES)) begin
            body[cnt[1:0]] <= req_data;
         end
      end
   end

   // Tuner settings applied only on a granted request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_cfg <= '0;
         rx_cfg <= '0;
         tx_apply <= 1'b0;
         rx_apply <= 1'b0;
         ib_accept <= 1'b0;
         tx_rate_kbps <= hctm_pkg::KBPS_256;
         rx_rate_kbps <= hctm_pkg::KBPS_2048;
         rx_freq_10khz <= hctm_pkg::RX_FREQ_BASE;
         last_tx_status <= 8'h00;
         last_rx_status <= 8'h00;
      end else if (ce) begin
         tx_apply <= 1'b0;
         rx_apply <= 1'b0;
         ib_accept <= 1'b0;
         if (state == S_EVAL && sess_active) begin
            if (tag_buf == hctm_pkg::TAG_TX_REQ) begin
               last_tx_status <= eval_status;
               if (eval_status == hctm_pkg::ST_GRANTED) begin
                  tx_cfg.transmit_freq_khz <= req_freq;
                  tx_cfg.transmit_power_code <= body[2];
                  tx_cfg.transmit_rate_code <= body[3][7:6];
                  tx_rate_kbps <= hctm_pkg::tx_kbps(body[3][7:6]);
                  tx_apply <= 1'b1;
               end
            end
            if (tag_buf == hctm_pkg::TAG_RX_REQ &&
                eval_status == hctm_pkg::ST_GRANTED) begin
               rx_cfg.receive_freq_code <= {body[0][2:0], body[1]};
               rx_freq_10khz <= hctm_pkg::RX_FREQ_BASE + 16'(
                  {body[0][2:0], body[1]} * hctm_pkg::RX_FREQ_STEP);
               rx_cfg.receive_rate_code <= body[2][7:6];
               rx_rate_kbps <= hctm_pkg::rx_kbps(body[2][7:6]);
               rx_cfg.spectrum_invert_bit <= body[2][0];
               rx_apply <= 1'b1;
            end
            if (tag_buf == hctm_pkg::TAG_IB_REQ &&
                eval_status == hctm_pkg::ST_GRANTED) begin
               ib_accept <= 1'b1;
            end
         end
         if (cnf_start && cnf_tag == hctm_pkg::TAG_RX_CNF) begin
            last_rx_status <= cnf_status;
         end
      end
   end

   // Confirmation serializer
   hctm_cnf_tx u_cnf (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .start(cnf_start),
      .tag(cnf_tag),
      .status(cnf_status),
      .busy(cnf_busy),
      .out_valid(cnf_valid),
      .out_data(cnf_data),
      .out_last(cnf_last),
      .out_ready(cnf_ready)
   );

   // APB decode; zero wait states while enabled
   assign pready = ce;
   assign mapped = paddr[1:0] == 2'b00 && paddr <= hctm_pkg::REG_DROPS;
   assign pslverr = psel && penable && !mapped;
   assign wr_en = psel && penable && pready && pwrite && mapped;

   // Software-written configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= hctm_pkg::hctm_ctrl_t'(hctm_pkg::CTRL_RST);
         tx_limit <= hctm_pkg::TX_LIMIT_RST;
         tx_power_max <= hctm_pkg::TX_POWER_RST;
         rx_limit <= hctm_pkg::RX_LIMIT_RST;
      end else if (ce && wr_en) begin
         case (paddr)
            hctm_pkg::REG_CTRL: ctrl <= hctm_pkg::hctm_ctrl_t'(pwdata[7:0]);
            hctm_pkg::REG_TX_LIMIT: tx_limit <= pwdata;
            hctm_pkg::REG_TX_POWER: tx_power_max <= pwdata[7:0];
            hctm_pkg::REG_RX_LIMIT: rx_limit <= pwdata[10:0];
            default: ;
         endcase
      end
   end

   // Read data prepared in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (ce && psel && !penable) begin
         case (paddr)
            hctm_pkg::REG_CTRL: prdata <= {24'h00_0000, ctrl};
            hctm_pkg::REG_TX_LIMIT: prdata <= tx_limit;
            hctm_pkg::REG_TX_POWER: prdata <= {24'h00_0000, tx_power_max};
            hctm_pkg::REG_RX_LIMIT: prdata <= {21'h00_0000, rx_limit};
            hctm_pkg::REG_STATUS:
               prdata <= {5'h00, state, last_rx_status, last_tx_status,
                          7'h00, sess_active};
            hctm_pkg::REG_TX_CFG: prdata <= {6'h00, tx_cfg};
            hctm_pkg::REG_RX_CFG: prdata <= {18'h0_0000, rx_cfg};
            hctm_pkg::REG_DROPS: prdata <= {16'h0000, drops};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

endmodule : hctm_top

// ### bench/hctm_check_sva.sv
// Port assertions for the host-control message handler
`timescale 1ns/1ps
module hctm_check #(
   parameter int RX_TIMEOUT = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic sess_open_req,
   input wire logic sess_close,
   input wire logic sess_active,
   input wire logic sess_open_ack,
   input wire logic sess_open_nak,
   input wire logic req_ready,
   input wire logic cnf_valid,
   input wire logic [7:0] cnf_data,
   input wire logic cnf_ready,
   input hctm_pkg::hctm_tx_cfg_t tx_cfg,
   input wire logic [11:0] tx_rate_kbps,
   input wire logic tx_apply,
   input hctm_pkg::hctm_rx_cfg_t rx_cfg,
   input wire logic [15:0] rx_freq_10khz,
   input wire logic [11:0] rx_rate_kbps,
   input wire logic rx_apply
);
   localparam int RX_BOUND = RX_TIMEOUT + 8;
   localparam logic [11:0] TXR [4] = '{12'h100, 12'h800, 12'h608, 12'hC10};
   localparam logic [11:0] RXR [4] = '{12'h800, 12'h800, 12'h608, 12'hC10};
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_open_answered: assert property (
      sess_open_req && ce && !sess_close |=> sess_open_ack != sess_open_nak)
      else $error("open unanswered");
   a_second_refused: assert property (
      sess_open_req && ce && sess_active && !sess_close |=> sess_open_nak)
      else $error("second open taken");
   a_no_stray_ack: assert property (
      !sess_open_req |=> !sess_open_ack && !sess_open_nak)
      else $error("stray open answer");
   a_cnf_holds: assert property (
      cnf_valid && !cnf_ready && ce |=> cnf_valid && $stable(cnf_data))
      else $error("confirm byte lost");
   a_cnf_blocks_req: assert property (
      cnf_valid |-> !req_ready)
      else $error("request during confirm");
   a_rx_freq_calc: assert property (
      rx_apply |=> rx_freq_10khz ==
         16'(rx_cfg.receive_freq_code) * 16'h0005 + 16'h1388)
      else $error("rx freq wrong");
   a_tx_rate_map: assert property (
      tx_apply |=> tx_rate_kbps == TXR[tx_cfg.transmit_rate_code])
      else $error("tx rate wrong");
   a_rx_rate_map: assert property (
      rx_apply |=> rx_rate_kbps == RXR[rx_cfg.receive_rate_code])
      else $error("rx rate wrong");
   a_rx_no_early: assert property (
      rx_apply |=> !cnf_valid)
      else $error("rx confirm early");
   a_rx_deadline: assert property (
      rx_apply |-> ##[1:RX_BOUND] cnf_valid)
      else $error("receive confirm late");
endmodule : hctm_check
bind hctm_top hctm_check #(.RX_TIMEOUT(RX_TIMEOUT)) u_check (
   .pclk, .presetn, .ce, .sess_open_req, .sess_close, .sess_active,
   .sess_open_ack, .sess_open_nak, .req_ready, .cnf_valid, .cnf_data,
   .cnf_ready, .tx_cfg, .tx_rate_kbps, .tx_apply, .rx_cfg,
   .rx_freq_10khz, .rx_rate_kbps, .rx_apply);

// ### bench/hctm_card_model.sv
// Card-side model: sends request bytes, collects confirmation bytes
`timescale 1ns/1ps
module hctm_card_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   output logic req_valid,
   output logic [7:0] req_data,
   input wire logic req_ready,
   input wire logic cnf_valid,
   input wire logic [7:0] cnf_data,
   input wire logic cnf_last,
   output logic cnf_ready
);
   logic [7:0] out_q[$];
   logic [8:0] in_q[$];
   // Byte stream out, held until taken; idle data toggles
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         req_valid <= 1'b0;
         req_data <= 8'h00;
         cnf_ready <= 1'b0;
      end else begin
         if (req_valid && req_ready) begin
            void'(out_q.pop_front());
         end
         req_valid <= out_q.size() != 0;
         req_data <= out_q.size() != 0 ? out_q[0] : ~req_data;
         cnf_ready <= slow ? ~cnf_ready : 1'b1;
         if (cnf_valid && cnf_ready) begin
            in_q.push_back({cnf_last, cnf_data});
         end
      end
   end
endmodule : hctm_card_model

// ### bench/hctm_top_bench.sv
// Self-checking bench for the host-control message handler
`timescale 1ns/1ps
module hctm_top_bench;
   logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
   logic sess_open_req = 0, sess_close = 0, slow = 0, lock_en = 0, err;
   logic [7:0] paddr = 8'h00, req_data, cnf_data;
   logic [31:0] pwdata = 32'h0, sess_res_id = 32'h0, prdata, q;
   logic pready, pslverr, sess_open_ack, sess_open_nak, sess_active;
   logic req_valid, req_ready, cnf_valid, cnf_last, cnf_ready, rx_locked;
   logic tx_apply, rx_apply, ib_accept;
   logic [11:0] tx_rate_kbps, rx_rate_kbps;
   logic [15:0] rx_freq_10khz;
   logic [2:0] lk_cnt = 3'h0;
   hctm_pkg::hctm_tx_cfg_t tx_cfg;
   hctm_pkg::hctm_rx_cfg_t rx_cfg;
   int fails = 0, check_count = 0, i;
   localparam logic [11:0] TXR [4] = '{12'h100, 12'h800, 12'h608, 12'hC10};
   localparam logic [11:0] RXR [4] = '{12'h800, 12'h800, 12'h608, 12'hC10};
   hctm_top #(.RX_TIMEOUT(20)) u_hctm_top (.*);
   hctm_card_model u_card (.*);
   initial forever #10 pclk = ~pclk;
   // Tuner drops lock on apply, regains it four cycles later
   always @(posedge pclk) lk_cnt <= rx_apply ? 3'h4 : lk_cnt - 3'(lk_cnt != 0);
   assign rx_locked = lock_en && lk_cnt == 3'h0 && !rx_apply;
   task automatic chk(input string nm, input logic [31:0] ex,
         input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk
   // One APB transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] ex);
      apb(1'b0, a, 32'h0);
      chk("read data", ex, q);
   endtask : rd
   task automatic sopen(input logic [31:0] id, input logic ack);
      @(posedge pclk);
      sess_open_req <= 1'b1;
      sess_res_id <= id;
      @(posedge pclk);
      sess_open_req <= 1'b0;
      @(posedge pclk);
      chk("open answer", {ack, !ack}, {sess_open_ack, sess_open_nak});
   endtask : sopen
   // Request message out, five confirmation bytes back
   task automatic msg(input logic [7:0] t, input logic [7:0] len,
         input logic [31:0] body, input int n, input logic [7:0] st);
      logic [7:0] e[5] = '{8'h9F, 8'h84, t + 8'h01, 8'h01, st};
      int k;
      u_card.out_q = {8'h9F, 8'h84, t, len};
      for (k = 0; k < n; k++) u_card.out_q.push_back(body[31-8*k -: 8]);
      for (k = 0; k < 2000 && u_card.in_q.size() < 5; k++) @(posedge pclk);
      for (k = 0; k < 5; k++) chk("cnf byte", {k == 4, e[k]}, u_card.in_q[k]);
      u_card.in_q.delete();
   endtask : msg
   task automatic summarize;
      if (fails == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize
   initial begin
      #2_000_000;
      fails++;
      summarize();
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd(8'h04, 32'hFFFF_0000);
      rd(8'h0C, 32'h0000_07FF);
      apb(1'b1, 8'h1C, 32'h0000_FFFF);
      rd(8'h1C, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", 32'h1, 32'(err));
      apb(1'b1, 8'h04, 32'hC350_03E8);
      apb(1'b1, 8'h00, 32'h0000_000B);
      sopen(hctm_pkg::RES_ID_MULTI, 1'b0);
      sopen(hctm_pkg::RES_ID_SINGLE, 1'b1);
      sopen(hctm_pkg::RES_ID_SINGLE, 1'b0);
      for (i = 0; i < 4; i++) begin
         msg(8'h04, 8'h04, {16'h1F40, 8'h10, 2'(i), 6'h3F}, 4, 8'h00);
         chk("tx rate", 32'(TXR[i]), 32'(tx_rate_kbps));
      end
      chk("tx cfg", {16'h1F40, 8'h10, 2'b11}, 32'(tx_cfg));
      msg(8'h04, 8'h04, 32'hFFFF_1000, 4, 8'h03);
      msg(8'h04, 8'h03, 32'h1F40_1000, 3, 8'h03);
      chk("tx cfg kept", {16'h1F40, 8'h10, 2'b11}, 32'(tx_cfg));
      apb(1'b1, 8'h00, 32'h0000_000F);
      msg(8'h04, 8'h04, 32'h1F40_1000, 4, 8'h02);
      apb(1'b1, 8'h00, 32'h0000_0009);
      slow <= 1'b1;
      msg(8'h04, 8'h04, 32'h1F40_1000, 4, 8'h01);
      lock_en <= 1'b1;
      for (i = 0; i < 4; i++) begin
         msg(8'h06, 8'h03, {16'h012C, 2'(i), 5'h00, i[0], 8'h00}, 3, 8'h00);
         chk("rx rate", 32'(RXR[i]), 32'(rx_rate_kbps));
         chk("rx cfg", {11'h12C, 2'(i), i[0]}, 32'(rx_cfg));
      end
      chk("rx freq", 32'h1964, 32'(rx_freq_10khz));
      msg(8'h06, 8'h03, 32'h092C_4000, 3, 8'h03);
      chk("rx cfg kept", {11'h12C, 2'b11, 1'b1}, 32'(rx_cfg));
      lock_en <= 1'b0;
      msg(8'h06, 8'h03, 32'h0064_8000, 3, 8'h04);
      msg(8'h08, 8'h03, 32'h0100_2000, 3, 8'h04);
      apb(1'b1, 8'h00, 32'h0000_0040);
      msg(8'h08, 8'h03, 32'h0100_2000, 3, 8'h00);
      msg(8'h06, 8'h03, 32'h0064_8000, 3, 8'h01);
      summarize();
   end
endmodule : hctm_top_bench
